// File: verilog/rsm_consts.svh
/*
 Constants for the reference status and event monitor: register offsets,
 field positions, reset values and timing counts.
 Assumes it is included by its bare name ahead of any code that uses it.
*/
// Summary of operation
// - Per reference, one status bit per loop marks use; loop 3 bit 7, loop 0 bit 4.
// - Valid bit set only when frequency in limits and validation timer expired.
// - Fault bit set whenever frequency is outside the programmed limits.
// - Too-fast bit set when frequency exceeds the profile upper bound.
// - Too-slow bit set when frequency falls below the profile lower bound.
// - With no signal detected, too-fast and too-slow may both read set.
// - Unmasked event sets its monitor bit to one and holds it.
// - Writing one to a clearing register bit clears that monitor bit.
// - Clear-all bit in the first clearing register clears every monitor bit.
// - Device reset returns all monitor bits to zero.
// - Common register bits 7..3 flag system clock PLL lock, stability, calibration.
// - Watchdog expiry in common bit 2; bits 1 and 0 reserved.
// - Per reference: validated, fault cleared, faulted; A/C bits 2:0, B/D 6:4.
// - Loop 0 phase lock gain/loss bits 0/1, frequency lock gain/loss bits 2/3.
// - Loop 0 slew limit enter/exit bits 4/5, clamp enter/exit bits 6/7.
// - Loop 0 switching bit 7, free run 6, holdover 5, history update 4.
// - Loop 0 activation of references A..D in bits 0..3.
// - Loop 0 demap step bit 7, unclamped 6, clamped 5; sync event bit 4.
// - Analog loop 0 unlock bit 3, lock 2, calibration done 1, started 0.
// - Reference status registers are read only; writes are ignored.
`ifndef RSM_CONSTS_SVH
`define RSM_CONSTS_SVH

// ==========================================================
// Register offsets
`define RSM_OFS_UPDATE 16'h000f
`define RSM_OFS_REF_A_STATUS 16'h0d02
`define RSM_OFS_REF_B_STATUS 16'h0d03
`define RSM_OFS_REF_C_STATUS 16'h0d04
`define RSM_OFS_REF_D_STATUS 16'h0d05
`define RSM_OFS_COMMON_EVENT 16'h0d08
`define RSM_OFS_REF_AB_EVENT 16'h0d09
`define RSM_OFS_REF_CD_EVENT 16'h0d0a
`define RSM_OFS_LOOP0_LOCK_EVENT 16'h0d0b
`define RSM_OFS_LOOP0_STATE_EVENT 16'h0d0c
`define RSM_OFS_LOOP0_AUX_EVENT 16'h0d0d
`define RSM_OFS_MASK_BASE 16'h010f
`define RSM_OFS_CLEAR_BASE 16'h0a05

// ==========================================================
// Field positions and values
`define RSM_STAT_ACTIVE_LSB 4
`define RSM_STAT_VALID 3
`define RSM_STAT_FAULT 2
`define RSM_STAT_FAST 1
`define RSM_STAT_SLOW 0
`define RSM_CLR_ALL_BIT 0
`define RSM_UPDATE_VAL 8'h01
`define RSM_MASK_RESET 8'h00
`define RSM_FLAG_RESET 8'h00
`define RSM_STATUS_RESET 8'h00

// ==========================================================
// Counts
`define RSM_NUM_REF 4
`define RSM_NUM_EVREG 6
`define RSM_VALID_CYCLES 1000

`endif

// File: verilog/rsm_pkg.sv
/*
 Types for the reference status and event monitor.
 Assumes rsm_consts.svh is on the include path.
*/
`default_nettype none
package rsm_pkg;
   // Measurement result for one reference
   typedef struct packed {
      logic no_signal;
      logic too_fast;
      logic too_slow;
   } rsm_meas_s;

   // Reference selection of one digital loop
   typedef struct packed {
      logic busy;
      logic [1:0] ref_idx;
   } rsm_loop_sel_s;

   // System clock PLL and watchdog levels
   typedef struct packed {
      logic sys_locked;
      logic sys_stable;
      logic sys_cal_busy;
      logic watchdog_expired;
   } rsm_common_s;

   // Loop 0 and analog loop 0 levels
   typedef struct packed {
      logic phase_lock;
      logic freq_lock;
      logic slew_limit;
      logic freq_clamp;
      logic switching;
      logic free_run;
      logic holdover;
      logic history_upd;
      logic demap_step;
      logic demap_clamp;
      logic dist_sync;
      logic apll_lock;
      logic apll_cal_busy;
   } rsm_loop0_s;
endpackage
`default_nettype wire

// File: verilog/rsm_monitor.sv
/*
 Reference status readback and sticky event monitor for a four reference,
 four loop clock translator.
 Assumes all status inputs come from logic on CLK_SYS and that the register
 port follows a one-cycle strobe protocol with read data a cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsm_consts.svh"
module rsm_monitor
   import rsm_pkg::*;
#(
   parameter int VALID_CYCLES = `RSM_VALID_CYCLES
)
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [15:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire rsm_meas_s [3:0] REF_MEAS,
   input wire rsm_loop_sel_s [3:0] LOOP_SEL,
   input wire rsm_common_s COMMON_IN,
   input wire rsm_loop0_s LOOP0_IN
);

   localparam int NR = `RSM_NUM_REF;
   localparam int NE = `RSM_NUM_EVREG;
   localparam int CW = $clog2(VALID_CYCLES + 1);

   // ==========================================================
   // Reference qualification
   logic [NR-1:0] ref_fast;
   logic [NR-1:0] ref_slow;
   logic [NR-1:0] ref_fault;
   logic [NR-1:0] ref_valid;
   logic [CW-1:0] vcnt [NR];
   logic [7:0] live_status [NR];
   logic [3:0] act [NR];

   genvar r;
   genvar l;
   generate
      for (r = 0; r < NR; r++)
      begin : g_ref
         // Lost signal reads as both fast and slow
         assign ref_fast[r] = REF_MEAS[r].too_fast | REF_MEAS[r].no_signal;
         assign ref_slow[r] = REF_MEAS[r].too_slow | REF_MEAS[r].no_signal;
         assign ref_fault[r] = ref_fast[r] | ref_slow[r];
         assign ref_valid[r] = ~ref_fault[r] && (vcnt[r] == CW'(VALID_CYCLES));

         // Validation timer restarts on any excursion
         always_ff @(posedge CLK_SYS or posedge RST)
         begin
            if (RST)
               vcnt[r] <= '0;
            else if (ref_fault[r])
               vcnt[r] <= '0;
            else if (vcnt[r] != CW'(VALID_CYCLES))
               vcnt[r] <= vcnt[r] + CW'(1);
         end

         // Loop use of this reference
         for (l = 0; l < 4; l++)
         begin : g_loop
            assign act[r][l] = LOOP_SEL[l].busy && (LOOP_SEL[l].ref_idx == 2'(r));
         end

         // Live status byte
         assign live_status[r] = {act[r], ref_valid[r], ref_fault[r], ref_fast[r], ref_slow[r]};
      end
   endgenerate

   // ==========================================================
   // Register decode
   wire wr_update = REG_WR && (REG_ADDR == `RSM_OFS_UPDATE) && (REG_WDATA == `RSM_UPDATE_VAL);
   logic [NR-1:0] hit_stat;
   logic [NE-1:0] hit_event;
   logic [NE-1:0] hit_mask;
   logic [NE-1:0] hit_clear;
   wire clear_all = REG_WR && hit_clear[0] && REG_WDATA[`RSM_CLR_ALL_BIT];

   genvar i;
   generate
      for (i = 0; i < NR; i++)
      begin : g_dec_stat
         assign hit_stat[i] = (REG_ADDR == 16'(`RSM_OFS_REF_A_STATUS + i));
      end
      for (i = 0; i < NE; i++)
      begin : g_dec_ev
         assign hit_event[i] = (REG_ADDR == 16'(`RSM_OFS_COMMON_EVENT + i));
         assign hit_mask[i] = (REG_ADDR == 16'(`RSM_OFS_MASK_BASE + i));
         assign hit_clear[i] = (REG_ADDR == 16'(`RSM_OFS_CLEAR_BASE + i));
      end
   endgenerate

   // ==========================================================
   // Status snapshot, refreshed by the update write
   logic [7:0] status_snap [NR];

   generate
      for (i = 0; i < NR; i++)
      begin : g_snap
         // Writes to the status offsets never reach here
         always_ff @(posedge CLK_SYS or posedge RST)
         begin
            if (RST)
               status_snap[i] <= `RSM_STATUS_RESET;
            else if (wr_update)
               status_snap[i] <= live_status[i];
         end
      end
   endgenerate

   // ==========================================================
   // Previous levels for edge detection
   rsm_common_s com_q;
   rsm_loop0_s l0_q;
   logic [NR-1:0] valid_q;
   logic [NR-1:0] fault_q;
   logic [NR-1:0] act0_q;
   logic [NR-1:0] act0;

   generate
      for (i = 0; i < NR; i++)
      begin : g_act0
         assign act0[i] = act[i][0];
      end
   endgenerate

   // Level history, one cycle deep
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         com_q <= '0;
         l0_q <= '0;
         valid_q <= '0;
         fault_q <= '0;
         act0_q <= '0;
      end
      else
      begin
         com_q <= COMMON_IN;
         l0_q <= LOOP0_IN;
         valid_q <= ref_valid;
         fault_q <= ref_fault;
         act0_q <= act0;
      end
   end

   // Rising and falling edges, one cycle each
   wire rsm_common_s com_rise = COMMON_IN & ~com_q;
   wire rsm_common_s com_fall = ~COMMON_IN & com_q;
   wire rsm_loop0_s l0_rise = LOOP0_IN & ~l0_q;
   wire rsm_loop0_s l0_fall = ~LOOP0_IN & l0_q;
   wire [NR-1:0] valid_rise = ref_valid & ~valid_q;
   wire [NR-1:0] fault_rise = ref_fault & ~fault_q;
   wire [NR-1:0] fault_fall = ~ref_fault & fault_q;
   wire [NR-1:0] act0_rise = act0 & ~act0_q;

   // ==========================================================
   // Event bytes in register order
   logic [7:0] raw [NE];
   logic [2:0] ev_ref [NR];

   generate
      for (i = 0; i < NR; i++)
      begin : g_evref
         assign ev_ref[i] = {valid_rise[i], fault_fall[i], fault_rise[i]};
      end
   endgenerate

   // Common functions, reserved low bits stay zero
   assign raw[0] = {com_fall.sys_locked, com_rise.sys_stable, com_rise.sys_locked,
                    com_fall.sys_cal_busy, com_rise.sys_cal_busy,
                    com_rise.watchdog_expired, 2'b00};
   // Reference pairs, bits 7 and 3 reserved
   assign raw[1] = {1'b0, ev_ref[1], 1'b0, ev_ref[0]};
   assign raw[2] = {1'b0, ev_ref[3], 1'b0, ev_ref[2]};
   // Loop 0 lock, slew and clamp
   assign raw[3] = {l0_fall.freq_clamp, l0_rise.freq_clamp,
                    l0_fall.slew_limit, l0_rise.slew_limit,
                    l0_fall.freq_lock, l0_rise.freq_lock,
                    l0_fall.phase_lock, l0_rise.phase_lock};
   // Loop 0 state changes and reference activation
   assign raw[4] = {l0_rise.switching, l0_rise.free_run,
                    l0_rise.holdover, l0_rise.history_upd,
                    act0_rise};
   // Loop 0 demapping, sync and analog loop
   assign raw[5] = {l0_rise.demap_step, l0_fall.demap_clamp,
                    l0_rise.demap_clamp, l0_rise.dist_sync,
                    l0_fall.apll_lock, l0_rise.apll_lock,
                    l0_fall.apll_cal_busy, l0_rise.apll_cal_busy};

   // ==========================================================
   // Mask registers and sticky flags
   logic [7:0] mask [NE];
   logic [7:0] flag [NE];
   logic [7:0] clr [NE];
   logic [7:0] set [NE];

   generate
      for (i = 0; i < NE; i++)
      begin : g_flag
         // Clear strobes from the clearing registers
         assign clr[i] = ((REG_WR && hit_clear[i]) ? REG_WDATA : 8'h00) | {8{clear_all}};
         // Masked events are dropped, not deferred
         assign set[i] = raw[i] & ~mask[i];

         // Mask register, one suppresses
         always_ff @(posedge CLK_SYS or posedge RST)
         begin
            if (RST)
               mask[i] <= `RSM_MASK_RESET;
            else if (REG_WR && hit_mask[i])
               mask[i] <= REG_WDATA;
         end

         // Set wins over a clear in the same cycle
         always_ff @(posedge CLK_SYS or posedge RST)
         begin
            if (RST)
               flag[i] <= `RSM_FLAG_RESET;
            else
               flag[i] <= (flag[i] & ~clr[i]) | set[i];
         end
      end
   endgenerate

   // ==========================================================
   // Read data mux, unmapped offsets read zero
   logic [7:0] rd_mux;

   always_comb
   begin
      rd_mux = 8'h00;
      for (int k = 0; k < NR; k++)
      begin
         if (hit_stat[k])
            rd_mux = status_snap[k];
      end
      for (int k = 0; k < NE; k++)
      begin
         if (hit_event[k])
            rd_mux = flag[k];
         if (hit_mask[k])
            rd_mux = mask[k];
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         REG_RDATA <= 8'h00;
      else
         REG_RDATA <= REG_RD ? rd_mux : 8'h00;
   end

endmodule
`default_nettype wire

// File: dv/rsm_monitor_assertions.sv
/*
 Checker for the rsm_monitor register port and sticky event flags.
 Assumes the loop0_lock_event_flags mask stays clear while lock events are checked.
*/
`timescale 1ns/1ps
`default_nettype none
module rsm_chk
   import rsm_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [15:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire rsm_common_s COMMON_IN,
   input wire rsm_loop0_s LOOP0_IN
);
   // ========
   // Read port and flag properties
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 8'h00)
      else $error("read data not zero outside a read");
   a_common_rsvd: assert property (REG_RD && REG_ADDR == 16'h0d08 |=> REG_RDATA[1:0] == 2'b00)
      else $error("common reserved bits set");
   a_refev_rsvd: assert property (REG_RD && REG_ADDR inside {16'h0d09, 16'h0d0a}
      |=> !REG_RDATA[7] && !REG_RDATA[3]) else $error("reference event reserved bits set");
   a_fault_range: assert property (REG_RD && REG_ADDR inside {[16'h0d02:16'h0d05]}
      |=> REG_RDATA[2] == (REG_RDATA[1] | REG_RDATA[0])) else $error("fault disagrees with fast or slow");
   a_valid_clean: assert property (REG_RD && REG_ADDR inside {[16'h0d02:16'h0d05]}
      |=> !(REG_RDATA[3] && REG_RDATA[2])) else $error("valid and fault both set");
   a_flag_sticky: assert property (REG_RD && REG_ADDR == 16'h0d0b ##2 REG_RD && REG_ADDR == 16'h0d0b
      && !$past(REG_WR) |=> (REG_RDATA & $past(REG_RDATA, 2)) == $past(REG_RDATA, 2))
      else $error("sticky flag lost without clear");
   a_lock_event: assert property ($rose(LOOP0_IN.phase_lock) ##1 REG_RD && REG_ADDR == 16'h0d0b
      |=> REG_RDATA[0] == 1'b1) else $error("phase lock event not flagged");
   a_set_wins: assert property ($rose(LOOP0_IN.freq_lock) && REG_WR && REG_ADDR == 16'h0a08
      ##1 !REG_WR ##1 REG_RD && REG_ADDR == 16'h0d0b |=> REG_RDATA[2] == 1'b1) else $error("event lost to clear");
   a_clear_all: assert property (REG_WR && REG_ADDR == 16'h0a05 && REG_WDATA[0] && $stable(COMMON_IN)
      ##1 $stable(COMMON_IN) ##1 REG_RD && REG_ADDR == 16'h0d08 && $stable(COMMON_IN)
      |=> REG_RDATA == 8'h00) else $error("clear all left a flag");
   a_mask_rw: assert property (REG_WR && REG_ADDR == 16'h010f ##1 !REG_WR ##1 REG_RD && REG_ADDR == 16'h010f
      |=> REG_RDATA == $past(REG_WDATA, 3)) else $error("mask readback wrong");
endmodule
bind rsm_monitor rsm_chk i_chk (.CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .COMMON_IN(COMMON_IN), .LOOP0_IN(LOOP0_IN));
`default_nettype wire

// File: dv/tb_top.sv
/*
 Self-checking bench for rsm_monitor: status snapshot, event flags, masks, clears.
 Assumes the checker file is compiled alongside and binds itself in.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top
   import rsm_pkg::*;
;
   // ========
   // Stimulus signals and event table
   localparam int VC = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   rsm_meas_s [3:0] meas = '0;
   rsm_loop_sel_s [3:0] sel = '0;
   logic [16:0] ev_in = '0;
   logic [16:0][7:0] ev_reg = {{4{8'h08}}, {4{8'h0b}}, {4{8'h0c}}, {5{8'h0d}}};
   logic [16:0][3:0] rise_bit = 68'h56320246765475420;
   logic [16:0][3:0] fall_bit = 68'h78481357888886831; // 8 means no fall event
   int errors = 0;
   int checked = 0;

   // Clock and design
   always #10 clk = ~clk;
   rsm_monitor #(.VALID_CYCLES(VC)) i_dut (.CLK_SYS(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REF_MEAS(meas), .LOOP_SEL(sel),
      .COMMON_IN(ev_in[16:13]), .LOOP0_IN(ev_in[12:0]));

   // ========
   // Register access
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask

   // ========
   // Scenarios
   task automatic t_status();
      @(posedge clk);
      meas[0].too_fast <= 1'b1;
      meas[2].too_slow <= 1'b1;
      meas[3].no_signal <= 1'b1;
      sel[3] <= 3'b100;
      sel[1] <= 3'b110;
      sel[0] <= 3'b111;
      repeat (VC + 2) @(posedge clk);
      wr(16'h000f, 8'h01);
      rd(16'h0d02, 8'h86);
      rd(16'h0d03, 8'h08);
      rd(16'h0d04, 8'h25);
      rd(16'h0d05, 8'h17);
      wr(16'h0d03, 8'hff);
      rd(16'h0d03, 8'h08);
      rd(16'h0200, 8'h00);
   endtask
   task automatic t_refev();
      wr(16'h0a05, 8'h01);
      meas[0].too_fast <= 1'b0;
      meas[2].too_slow <= 1'b0;
      sel[0] <= 3'b101;
      repeat (VC + 2) @(posedge clk);
      rd(16'h0d09, 8'h06);
      rd(16'h0d0a, 8'h06);
      rd(16'h0d0c, 8'h02);
      wr(16'h0a06, 8'h02);
      rd(16'h0d09, 8'h04);
   endtask
   task automatic t_events();
      for (int k = 0; k < 17; k++)
      begin
         wr(16'h0a05, 8'h01);
         @(posedge clk);
         ev_in[k] <= 1'b1;
         rd({8'h0d, ev_reg[k]}, 8'h01 << rise_bit[k]);
         @(posedge clk);
         ev_in[k] <= 1'b0;
         rd({8'h0d, ev_reg[k]}, (8'h01 << rise_bit[k]) | (8'h01 << fall_bit[k]));
      end
   endtask
   task automatic t_mask();
      wr(16'h010f, 8'h20);
      rd(16'h010f, 8'h20);
      wr(16'h0a05, 8'h01);
      rd(16'h0d08, 8'h00);
      @(posedge clk);
      ev_in[16] <= 1'b1;
      rd(16'h0d08, 8'h00);
      wr(16'h010f, 8'h00);
      rd(16'h0d08, 8'h00);
      @(posedge clk);
      ev_in[16] <= 1'b0;
      rd(16'h0d08, 8'h80);
   endtask
   task automatic t_clear();
      @(posedge clk);
      ev_in[11] <= 1'b1;
      reg_wr <= 1'b1;
      reg_addr <= 16'h0a08;
      reg_wdata <= 8'h04;
      @(posedge clk);
      reg_wr <= 1'b0;
      rd(16'h0d0b, 8'h04);
      rd(16'h0d0b, 8'h04);
      wr(16'h0a08, 8'h04);
      rd(16'h0d0b, 8'h00);
      @(posedge clk);
      ev_in[11] <= 1'b0;
      rd(16'h0d0b, 8'h08);
      wr(16'h010f, 8'hff);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd(16'h0d0b, 8'h00);
      rd(16'h010f, 8'h00);
      wr(16'h0114, 8'h5a);
      rd(16'h0114, 8'h5a);
   endtask

   // ========
   // Verdict and main sequence
   task automatic conclude();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_status();
      t_refev();
      t_events();
      t_mask();
      t_clear();
      conclude();
   end
endmodule
`default_nettype wire
